// [verilog/usev_event_logic.sv]
// usb device state, control stage, frame number and pipe option logic
`timescale 1ns/100ps
module usev_event_logic
    import usev_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    input wire usev_link_s lk,
    output logic state_irq_req,
    output logic stage_irq_req,
    output logic frame_irq_req,
    output logic resume_irq_req,
    output logic stall_resp,
    output logic sof_interp_en,
    output usev_dev_e device_state,
    output usev_stage_e control_stage
);

    // ==========================================================
    // helpers
    function automatic usev_stage_e setup_stage(input logic dir_in, input logic has_data);
        if (!has_data)
        begin
            return STG_ND_STATUS;
        end
        return dir_in ? STG_RD_DATA : STG_WR_DATA;
    endfunction : setup_stage

    function automatic usev_pipe_s cfg_write(input usev_pipe_s old, input logic [15:0] w,
                                             input logic [3:0] num);
        usev_pipe_s r;
        r = old;
        r.ptype = w[CFG_TYPE_LSB +: 2];
        r.dir = w[CFG_DIR_BIT];
        r.ep = w[CFG_EP_LSB +: 4];
        if (num >= PIPE_FIRST && num <= PIPE_OPT_LAST)
        begin
            r.ready = w[CFG_READY_BIT];
            r.dbl = w[CFG_DOUBLE_BIT];
        end
        if ((num >= PIPE_CONT_FIRST && num <= PIPE_OPT_LAST)
            || (num >= PIPE_FIRST && num <= PIPE_BULK_LAST && r.ptype == TYPE_BULK))
        begin
            r.cont = w[CFG_CONT_BIT];
        end
        else
        begin
            r.cont = 1'b0;
        end
        return r;
    endfunction : cfg_write

    function automatic logic [15:0] cfg_read(input usev_pipe_s p);
        logic [15:0] v;
        v = 16'h0000;
        v[CFG_TYPE_LSB +: 2] = p.ptype;
        v[CFG_READY_BIT] = p.ready;
        v[CFG_DOUBLE_BIT] = p.dbl;
        v[CFG_CONT_BIT] = p.cont;
        v[CFG_DIR_BIT] = p.dir;
        v[CFG_EP_LSB +: 4] = p.ep;
        return v;
    endfunction : cfg_read

    // ==========================================================
    // state
    usev_st_s s_reg;
    usev_st_s s_next;
    logic sel_ok;
    logic [3:0] sel_idx;
    logic monitor_on;
    logic stage_err;
    logic sof_ok;

    assign sel_ok = s_reg.pipe_sel >= PIPE_FIRST && s_reg.pipe_sel <= PIPE_LAST;
    assign sel_idx = s_reg.pipe_sel - 4'h1;
    // lock monitor runs with enable and clock, stops on reset or suspend
    assign monitor_on = s_reg.usb_en && lk.clk_ok && !lk.bus_reset && !lk.suspend
                        && s_reg.dev != DEV_SUSPENDED;
    assign sof_ok = lk.sof_rx && !lk.sof_err && s_reg.periph;

    // ==========================================================
    // next state
    always_comb
    begin
        s_next = s_reg;
        stage_err = 1'b0;
        s_next.rdata = 16'h0000;

        // register reads
        if (rd)
        begin
            unique case (addr)
                OFS_CTRL:
                begin
                    s_next.rdata[CTRL_ENABLE_BIT] = s_reg.usb_en;
                    s_next.rdata[CTRL_PERIPH_BIT] = s_reg.periph;
                end
                OFS_IRQ_EN: s_next.rdata = s_reg.irq_en;
                OFS_IRQ_STS:
                begin
                    s_next.rdata[IRQ_STATE_BIT] = s_reg.st_irq;
                    s_next.rdata[IRQ_FRAME_BIT] = s_reg.fr_irq;
                    s_next.rdata[IRQ_RESUME_BIT] = s_reg.rs_irq;
                    s_next.rdata[IRQ_SEQERR_BIT] = s_reg.seq_err;
                    s_next.rdata[IRQ_STAGE_BIT] = s_reg.stg_irq;
                    s_next.rdata[STS_DEV_LSB +: 3] = s_reg.dev;
                    s_next.rdata[STS_STAGE_LSB +: 3] = s_reg.stage;
                end
                OFS_DCP_CTRL: s_next.rdata[1:0] = s_reg.resp;
                OFS_FRAME:
                begin
                    s_next.rdata[10:0] = s_reg.frame;
                    s_next.rdata[FRAME_LOCK_BIT] = s_reg.locked;
                end
                OFS_PIPE_SEL: s_next.rdata[3:0] = s_reg.pipe_sel;
                OFS_PIPE_CFG: s_next.rdata = sel_ok ? cfg_read(s_reg.pipes[sel_idx]) : 16'h0000;
                default: s_next.rdata = 16'h0000;
            endcase
        end

        // register writes; status bits clear on a written zero, seq_err on a zero written to the stage bit
        if (wr)
        begin
            unique case (addr)
                OFS_CTRL:
                begin
                    s_next.usb_en = wdata[CTRL_ENABLE_BIT];
                    s_next.periph = wdata[CTRL_PERIPH_BIT];
                end
                OFS_IRQ_EN: s_next.irq_en = wdata;
                OFS_IRQ_STS:
                begin
                    if (!wdata[IRQ_STATE_BIT]) s_next.st_irq = 1'b0;
                    if (!wdata[IRQ_FRAME_BIT]) s_next.fr_irq = 1'b0;
                    if (!wdata[IRQ_RESUME_BIT]) s_next.rs_irq = 1'b0;
                    if (!wdata[IRQ_STAGE_BIT])
                    begin
                        s_next.stg_irq = 1'b0;
                        s_next.seq_err = 1'b0;
                    end
                end
                OFS_DCP_CTRL: s_next.resp = wdata[1:0];
                OFS_PIPE_SEL: s_next.pipe_sel = wdata[3:0];
                OFS_PIPE_CFG:
                begin
                    if (sel_ok)
                    begin
                        s_next.pipes[sel_idx] = cfg_write(s_reg.pipes[sel_idx], wdata,
                                                          s_reg.pipe_sel);
                    end
                end
                default: ;
            endcase
        end

        // device state; events set after writes so a set wins
        if (!s_reg.periph)
        begin
            s_next.dev = DEV_POWERED;
        end
        else if (lk.reset_done)
        begin
            s_next.dev = DEV_DEFAULT;
            s_next.st_irq = 1'b1;
        end
        else if (lk.suspend && s_reg.dev != DEV_SUSPENDED)
        begin
            s_next.dev_saved = s_reg.dev;
            s_next.dev = DEV_SUSPENDED;
            s_next.st_irq = 1'b1;
        end
        else if (lk.resume && s_reg.dev == DEV_SUSPENDED)
        begin
            s_next.dev = s_reg.dev_saved;
            s_next.rs_irq = 1'b1;
        end
        else if (lk.addressed && s_reg.dev == DEV_DEFAULT)
        begin
            s_next.dev = DEV_ADDRESS;
            s_next.st_irq = 1'b1;
        end
        else if (lk.configured && s_reg.dev == DEV_ADDRESS)
        begin
            s_next.dev = DEV_CONFIGURED;
            s_next.st_irq = 1'b1;
        end
        else if (lk.deconfigured && s_reg.dev == DEV_CONFIGURED)
        begin
            s_next.dev = DEV_ADDRESS;
            s_next.st_irq = 1'b1;
        end

        // control stage
        if (s_reg.periph)
        begin
            if (s_reg.stage == STG_SEQ_ERR)
            begin
                if (lk.setup_rx)
                begin
                    s_next.pend_setup = 1'b1;
                    s_next.pend_in = lk.setup_in;
                    s_next.pend_data = lk.setup_data;
                end
                if (!s_next.stg_irq && s_next.pend_setup)
                begin
                    s_next.stage = setup_stage(s_next.pend_in, s_next.pend_data);
                    s_next.pend_setup = 1'b0;
                    s_next.seen = 1'b0;
                    s_next.first_data = 1'b1;
                    s_next.stg_irq = s_reg.irq_en[IEN_SETUP_END];
                end
                else if (!s_next.stg_irq)
                begin
                    s_next.stage = STG_SETUP;
                end
            end
            else if (lk.setup_rx)
            begin
                s_next.stage = setup_stage(lk.setup_in, lk.setup_data);
                s_next.seen = 1'b0;
                s_next.first_data = 1'b1;
                if (s_reg.irq_en[IEN_SETUP_END]) s_next.stg_irq = 1'b1;
            end
            else
            begin
                unique case (s_reg.stage)
                    STG_SETUP: ;
                    STG_RD_DATA:
                    begin
                        if (lk.in_done) s_next.seen = 1'b1;
                        if (lk.tok_out || lk.tok_ping)
                        begin
                            if (!s_reg.seen)
                            begin
                                stage_err = 1'b1;
                            end
                            else
                            begin
                                s_next.stage = STG_RD_STATUS;
                                if (s_reg.irq_en[IEN_DATA_END]) s_next.stg_irq = 1'b1;
                            end
                        end
                    end
                    STG_RD_STATUS:
                    begin
                        if (lk.tok_in || (lk.data_rx && !lk.data_pid1))
                        begin
                            stage_err = 1'b1;
                        end
                        else if (lk.data_rx)
                        begin
                            s_next.stage = STG_SETUP;
                            if (s_reg.irq_en[IEN_STATUS_END]) s_next.stg_irq = 1'b1;
                        end
                    end
                    STG_WR_DATA:
                    begin
                        // the byte count against the request length is not checked
                        if (lk.data_rx)
                        begin
                            s_next.first_data = 1'b0;
                        end
                        if (lk.data_rx && s_reg.first_data && !lk.data_pid1)
                        begin
                            stage_err = 1'b1;
                        end
                        else if (lk.tok_in && !s_reg.seen)
                        begin
                            stage_err = 1'b1;
                        end
                        else if (lk.tok_in)
                        begin
                            s_next.stage = STG_WR_STATUS;
                            if (s_reg.irq_en[IEN_DATA_END]) s_next.stg_irq = 1'b1;
                        end
                        else if (lk.ack_sent)
                        begin
                            s_next.seen = 1'b1;
                        end
                    end
                    STG_WR_STATUS,
                    STG_ND_STATUS:
                    begin
                        if (lk.tok_out || lk.tok_ping)
                        begin
                            stage_err = 1'b1;
                        end
                        else if (lk.in_done)
                        begin
                            s_next.stage = STG_SETUP;
                            if (s_reg.irq_en[IEN_STATUS_END]) s_next.stg_irq = 1'b1;
                        end
                    end
                    default: s_next.stage = STG_SETUP;
                endcase
            end
            if (stage_err)
            begin
                s_next.stage = STG_SEQ_ERR;
                s_next.seq_err = 1'b1;
                s_next.stg_irq = 1'b1;
                s_next.resp = RESP_STALL;
            end
        end

        // frame number and lock monitor
        if (!monitor_on)
        begin
            s_next.locked = 1'b0;
            s_next.prev_valid = 1'b0;
        end
        else if (sof_ok && !lk.hs_mode)
        begin
            s_next.frame = lk.frame;
            s_next.fr_irq = 1'b1;
        end
        else if (sof_ok && !s_reg.locked)
        begin
            if (s_reg.prev_valid && lk.frame != s_reg.prev_frame)
            begin
                s_next.locked = 1'b1;
            end
            s_next.prev_frame = lk.frame;
            s_next.prev_valid = 1'b1;
        end
        else if (sof_ok && lk.frame != s_reg.frame)
        begin
            s_next.frame = lk.frame;
            s_next.fr_irq = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            s_reg <= ST_RESET;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // ==========================================================
    // outputs
    assign rdata = s_reg.rdata;
    assign state_irq_req = s_reg.st_irq && s_reg.irq_en[IRQ_STATE_BIT];
    assign stage_irq_req = s_reg.stg_irq;
    assign frame_irq_req = s_reg.fr_irq && s_reg.irq_en[IRQ_FRAME_BIT];
    assign resume_irq_req = s_reg.rs_irq && s_reg.irq_en[IRQ_RESUME_BIT];
    assign stall_resp = s_reg.resp[1];
    assign sof_interp_en = s_reg.locked && lk.hs_mode;
    assign device_state = s_reg.dev;
    assign control_stage = s_reg.stage;

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_stall_on_err;
        s_reg.stage != STG_SEQ_ERR && stage_err |=> s_reg.resp == RESP_STALL && s_reg.seq_err;
    endproperty
    a_stall_on_err: assert property (p_stall_on_err) else $error("no stall on error");

    property p_err_hold;
        s_reg.stage == STG_SEQ_ERR && s_reg.stg_irq && !(wr && addr == OFS_IRQ_STS)
            |=> s_reg.stage == STG_SEQ_ERR;
    endproperty
    a_err_hold: assert property (p_err_hold) else $error("error stage left early");

    property p_host_no_dev;
        !s_reg.periph |=> s_reg.dev == DEV_POWERED;
    endproperty
    a_host_no_dev: assert property (p_host_no_dev) else $error("state tracked in host");

    property p_host_no_stage;
        !s_reg.periph && !s_reg.stg_irq |=> !s_reg.stg_irq;
    endproperty
    a_host_no_stage: assert property (p_host_no_stage) else $error("stage irq in host");

    property p_reset_default;
        s_reg.periph && lk.reset_done |=> s_reg.dev == DEV_DEFAULT && s_reg.st_irq;
    endproperty
    a_reset_default: assert property (p_reset_default) else $error("no default state");

    property p_resume_quiet;
        s_reg.periph && s_reg.dev == DEV_SUSPENDED && lk.resume && !lk.reset_done
            && !s_reg.st_irq ##1 !wr |-> !s_reg.st_irq && s_reg.rs_irq;
    endproperty
    a_resume_quiet: assert property (p_resume_quiet) else $error("resume seen as state");

    property p_lock_cause;
        $rose(s_reg.locked) |-> $past(lk.sof_rx) && $past(s_reg.prev_valid)
            && $past(lk.frame) != $past(s_reg.prev_frame);
    endproperty
    a_lock_cause: assert property (p_lock_cause) else $error("lock without two frames");

    property p_monitor_stop;
        !s_reg.usb_en || lk.bus_reset |=> !s_reg.locked;
    endproperty
    a_monitor_stop: assert property (p_monitor_stop) else $error("lock kept when stopped");

    property p_fs_frame;
        monitor_on && sof_ok && !lk.hs_mode |=> s_reg.frame == $past(lk.frame) && s_reg.fr_irq;
    endproperty
    a_fs_frame: assert property (p_fs_frame) else $error("frame not updated");

    c_seq_err: cover property (s_reg.stage == STG_WR_DATA ##1 s_reg.stage == STG_SEQ_ERR);
    c_read_done: cover property (s_reg.stage == STG_RD_STATUS ##1 s_reg.stage == STG_SETUP);
    c_locked: cover property ($rose(s_reg.locked));
    c_setup_after_hold: cover property (s_reg.stage == STG_SEQ_ERR ##1 s_reg.stage == STG_RD_DATA);

endmodule : usev_event_logic

// [verilog/usev_pkg.sv]
// shared types and constants of the usb stage and event logic
package usev_pkg;

    // ==========================================================
    // widths
    localparam int DATA_W = 16;
    localparam int NUM_PIPES = 9;

    // ==========================================================
    // register offsets (word index on the plain register port)
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_IRQ_EN = 4'h1;
    localparam logic [3:0] OFS_IRQ_STS = 4'h2;
    localparam logic [3:0] OFS_DCP_CTRL = 4'h3;
    localparam logic [3:0] OFS_FRAME = 4'h4;
    localparam logic [3:0] OFS_PIPE_SEL = 4'h5;
    localparam logic [3:0] OFS_PIPE_CFG = 4'h6;

    // ==========================================================
    // field positions
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_PERIPH_BIT = 1;
    localparam int IRQ_STATE_BIT = 15;
    localparam int IRQ_FRAME_BIT = 14;
    localparam int IRQ_RESUME_BIT = 13;
    localparam int IRQ_SEQERR_BIT = 12;
    localparam int IRQ_STAGE_BIT = 11;
    localparam int IEN_SETUP_END = 0;
    localparam int IEN_DATA_END = 1;
    localparam int IEN_STATUS_END = 2;
    localparam int STS_DEV_LSB = 4;
    localparam int STS_STAGE_LSB = 0;
    localparam int FRAME_LOCK_BIT = 15;
    localparam int CFG_TYPE_LSB = 14;
    localparam int CFG_READY_BIT = 10;
    localparam int CFG_DOUBLE_BIT = 9;
    localparam int CFG_CONT_BIT = 8;
    localparam int CFG_DIR_BIT = 4;
    localparam int CFG_EP_LSB = 0;

    // ==========================================================
    // encodings and pipe limits
    localparam logic [1:0] RESP_NAK = 2'h0;
    localparam logic [1:0] RESP_STALL = 2'h2;
    localparam logic [1:0] TYPE_BULK = 2'h1;
    localparam logic [3:0] PIPE_FIRST = 4'h1;
    localparam logic [3:0] PIPE_OPT_LAST = 4'h5;
    localparam logic [3:0] PIPE_BULK_LAST = 4'h2;
    localparam logic [3:0] PIPE_CONT_FIRST = 4'h3;
    localparam logic [3:0] PIPE_LAST = 4'h9;

    typedef enum logic [2:0] {
        DEV_POWERED = 3'b000,
        DEV_DEFAULT = 3'b001,
        DEV_ADDRESS = 3'b010,
        DEV_CONFIGURED = 3'b011,
        DEV_SUSPENDED = 3'b100
    } usev_dev_e;

    typedef enum logic [2:0] {
        STG_SETUP = 3'b000,
        STG_RD_DATA = 3'b001,
        STG_RD_STATUS = 3'b010,
        STG_WR_DATA = 3'b011,
        STG_WR_STATUS = 3'b100,
        STG_ND_STATUS = 3'b101,
        STG_SEQ_ERR = 3'b110
    } usev_stage_e;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic bus_reset;
        logic reset_done;
        logic suspend;
        logic resume;
        logic addressed;
        logic configured;
        logic deconfigured;
        logic setup_rx;
        logic setup_in;
        logic setup_data;
        logic tok_in;
        logic tok_out;
        logic tok_ping;
        logic data_rx;
        logic data_pid1;
        logic in_done;
        logic ack_sent;
        logic sof_rx;
        logic sof_err;
        logic hs_mode;
        logic clk_ok;
        logic [10:0] frame;
    } usev_link_s;

    typedef struct packed {
        logic [1:0] ptype;
        logic ready;
        logic dbl;
        logic cont;
        logic dir;
        logic [3:0] ep;
    } usev_pipe_s;

    typedef struct packed {
        logic usb_en;
        logic periph;
        logic [15:0] irq_en;
        usev_dev_e dev;
        usev_dev_e dev_saved;
        logic st_irq;
        logic fr_irq;
        logic rs_irq;
        logic stg_irq;
        logic seq_err;
        usev_stage_e stage;
        logic seen;
        logic first_data;
        logic pend_setup;
        logic pend_in;
        logic pend_data;
        logic [1:0] resp;
        logic [10:0] frame;
        logic locked;
        logic prev_valid;
        logic [10:0] prev_frame;
        logic [3:0] pipe_sel;
        usev_pipe_s [NUM_PIPES-1:0] pipes;
        logic [15:0] rdata;
    } usev_st_s;

    localparam usev_st_s ST_RESET = '0;

endpackage : usev_pkg

// [tb/usev_host_model.sv]
// usb host model driving the link event carrier
`timescale 1ns/100ps
module usev_host_model
    import usev_pkg::*;
(
    input wire logic clk,
    output usev_link_s lk
);
    // ==========================================================
    // bus levels between events
    logic hs = 1'b0;
    logic ok = 1'b1;
    initial lk = '0;
    // speed and clock levels, applied with the next event
    task automatic levels(input logic h, input logic c);
        hs = h;
        ok = c;
    endtask : levels
    // ==========================================================
    // one event per call, one cycle long, frame inverted once released
    task automatic pulse(input usev_link_s ev);
        @(posedge clk);
        ev.hs_mode = hs;
        ev.clk_ok = ok;
        lk <= ev;
        @(posedge clk);
        ev = '0;
        ev.hs_mode = hs;
        ev.clk_ok = ok;
        ev.frame = ~lk.frame;
        lk <= ev;
    endtask : pulse
endmodule : usev_host_model

// [tb/usev_event_logic_bench.sv]
// self-checking bench of the usb stage and event logic
`timescale 1ns/100ps
module usev_event_logic_bench;
    import usev_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    usev_link_s lk;
    logic state_irq_req, stage_irq_req, frame_irq_req, resume_irq_req, stall_resp, sof_interp_en;
    usev_dev_e device_state;
    usev_stage_e control_stage;
    int failures = 0;
    int samples_checked = 0;
    always #20 clk = ~clk;
    // ==========================================================
    // design and host
    usev_event_logic usev_event_logic_inst (.clk(clk), .rstn(rstn), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .lk(lk),
        .state_irq_req(state_irq_req), .stage_irq_req(stage_irq_req),
        .frame_irq_req(frame_irq_req), .resume_irq_req(resume_irq_req),
        .stall_resp(stall_resp), .sof_interp_en(sof_interp_en),
        .device_state(device_state), .control_stage(control_stage));
    usev_host_model usev_host_model_inst (.clk(clk), .lk(lk));
    // ==========================================================
    // shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_check(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 check(rdata, exp);
    endtask : rd_check
    task automatic ev(input usev_link_s e);
        usev_host_model_inst.pulse(e);
        #1;
    endtask : ev
    // ==========================================================
    // scenarios
    task automatic t_state;
        ev('{bus_reset: 1'b1, default: 0});
        check(state_irq_req, 1'b0);
        ev('{reset_done: 1'b1, default: 0});
        check(device_state, DEV_DEFAULT);
        check(state_irq_req, 1'b1);
        rd_check(OFS_IRQ_STS, 16'h8010);
        wr_reg(OFS_IRQ_STS, 16'h0000);
        ev('{addressed: 1'b1, default: 0});
        check(device_state, DEV_ADDRESS);
        $display("device state test done");
    endtask : t_state
    task automatic t_seq_err;
        wr_reg(OFS_IRQ_STS, 16'h0000);
        ev('{setup_rx: 1'b1, setup_data: 1'b1, default: 0});
        check(control_stage, STG_WR_DATA);
        check(stage_irq_req, 1'b1);
        wr_reg(OFS_IRQ_STS, 16'h0000);
        ev('{tok_in: 1'b1, default: 0});
        check(control_stage, STG_SEQ_ERR);
        check(stall_resp, 1'b1);
        ev('{setup_rx: 1'b1, default: 0});
        check(control_stage, STG_SEQ_ERR);
        wr_reg(OFS_IRQ_STS, 16'h0000);
        #1 check(control_stage, STG_ND_STATUS);
        check(stage_irq_req, 1'b1);
        ev('{tok_out: 1'b1, default: 0});
        check(control_stage, STG_SEQ_ERR);
        wr_reg(OFS_IRQ_STS, 16'h0000);
        $display("sequence error test done");
    endtask : t_seq_err
    task automatic t_frame_pipe;
        ev('{sof_rx: 1'b1, frame: 11'h005, default: 0});
        check(frame_irq_req, 1'b1);
        rd_check(OFS_FRAME, 16'h0005);
        wr_reg(OFS_PIPE_SEL, 16'h0007);
        wr_reg(OFS_PIPE_CFG, 16'h4715);
        rd_check(OFS_PIPE_CFG, 16'h4015);
        wr_reg(OFS_PIPE_SEL, 16'h0003);
        wr_reg(OFS_PIPE_CFG, 16'h0702);
        rd_check(OFS_PIPE_CFG, 16'h0702);
        rd_check(4'hF, 16'h0000);
        $display("frame and pipe test done");
    endtask : t_frame_pipe
    task automatic t_hs_lock;
        usev_host_model_inst.levels(1'b1, 1'b1);
        wr_reg(OFS_IRQ_STS, 16'h0000);
        ev('{sof_rx: 1'b1, frame: 11'h008, default: 0});
        ev('{sof_rx: 1'b1, frame: 11'h008, default: 0});
        check(sof_interp_en, 1'b0);
        ev('{sof_rx: 1'b1, frame: 11'h009, default: 0});
        check(sof_interp_en, 1'b1);
        check(frame_irq_req, 1'b0);
        ev('{sof_rx: 1'b1, frame: 11'h00A, default: 0});
        check(frame_irq_req, 1'b1);
        rd_check(OFS_FRAME, 16'h800A);
        wr_reg(OFS_IRQ_STS, 16'h0000);
        ev('{sof_rx: 1'b1, frame: 11'h00A, default: 0});
        check(frame_irq_req, 1'b0);
        ev('{bus_reset: 1'b1, default: 0});
        check(sof_interp_en, 1'b0);
        $display("frame lock test done");
    endtask : t_hs_lock
    task automatic t_read_host;
        wr_reg(OFS_IRQ_STS, 16'h0000);
        ev('{setup_rx: 1'b1, setup_in: 1'b1, setup_data: 1'b1, default: 0});
        check(control_stage, STG_RD_DATA);
        ev('{in_done: 1'b1, default: 0});
        ev('{tok_out: 1'b1, default: 0});
        check(control_stage, STG_RD_STATUS);
        wr_reg(OFS_IRQ_STS, 16'h0000);
        ev('{data_rx: 1'b1, data_pid1: 1'b1, default: 0});
        check(control_stage, STG_SETUP);
        check(stage_irq_req, 1'b1);
        ev('{setup_rx: 1'b1, setup_in: 1'b1, setup_data: 1'b1, default: 0});
        ev('{tok_ping: 1'b1, default: 0});
        check(control_stage, STG_SEQ_ERR);
        wr_reg(OFS_IRQ_STS, 16'h0000);
        ev('{suspend: 1'b1, default: 0});
        check(device_state, DEV_SUSPENDED);
        wr_reg(OFS_IRQ_STS, 16'h0000);
        ev('{resume: 1'b1, default: 0});
        check(state_irq_req, 1'b0);
        check(resume_irq_req, 1'b1);
        check(device_state, DEV_ADDRESS);
        wr_reg(OFS_CTRL, 16'h0001);
        wr_reg(OFS_IRQ_STS, 16'h0000);
        ev('{setup_rx: 1'b1, default: 0});
        check(control_stage, STG_SETUP);
        check(stage_irq_req, 1'b0);
        ev('{reset_done: 1'b1, default: 0});
        check(device_state, DEV_POWERED);
        check(state_irq_req, 1'b0);
        $display("read, resume and host role test done");
    endtask : t_read_host
    // ==========================================================
    // closing and main sequence
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up
    initial
    begin
        #20000;
        failures++;
        wrap_up();
    end
    initial
    begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        wr_reg(OFS_CTRL, 16'h0003);
        wr_reg(OFS_IRQ_EN, 16'hE007);
        t_state();
        t_seq_err();
        t_frame_pipe();
        t_hs_lock();
        t_read_host();
        wrap_up();
    end
endmodule : usev_event_logic_bench
